/* core/sbtt_core.sv */
// Notes on behaviour
// - Data items are eight-bit bytes, starting only after own address is acknowledged.
// - Bits shift most significant first, least significant last, both directions.
// - The receiver of a full byte drives the data line low to acknowledge.
// - As receiver the slave drives its acknowledge during the ninth clock.
// - As transmitter, capture master acknowledge; on none, release data and await stop.
// - Without master acknowledge the data line stays released for the stop.
// - Sent bytes come from the data buffer; received bytes land there.
// - After a match the clock is held low until buffer write or read.
// - Time-out counter starts on start plus own-address match; clock falls clear it.
// - Time-out fires when elapsed time since last clock fall reaches period.
// - A stop condition ends time-out supervision.
// - On overflow the counter halts, enable clears and the flag sets.
// - A time-out raises the same interrupt as match and byte completion.
// - A time-out returns the state machine and shift logic to reset.
// - A time-out keeps buffer, own address, first control; second control resets.
// - The time-out flag stays set until software clears it.
// - Sixty-four periods: selection one to sixty-four times 32 sub clocks.
// - The sub clock keeps running always, so supervision always has a clock.
// - Counter ticks at sub clock over 32; period is select plus one ticks.
// - Own-address match sets the match flag and raises the interrupt.
// - Transmit-mode bit set means the slave sends; clear means it receives.
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module sbtt_core
#(
   parameter int unsigned SUB_DIV_P = sbtt_pkg::SUB_DIV
)
(
   input  wire logic                        clk_sys_i,
   input  wire logic                        nrst_i,
   input  wire logic [sbtt_pkg::AVS_AW-1:0] avs_address_i,
   input  wire logic                        avs_read_i,
   input  wire logic                        avs_write_i,
   input  wire logic [sbtt_pkg::AVS_DW-1:0] avs_writedata_i,
   input  wire logic [3:0]                  avs_byteenable_i,
   output logic      [sbtt_pkg::AVS_DW-1:0] avs_readdata_o,
   output logic                             avs_waitrequest_o,
   input  wire logic                        scl_i,
   output logic                             scl_o,
   output logic                             scl_oe_o,
   input  wire logic                        sda_i,
   output logic                             sda_o,
   output logic                             sda_oe_o,
   output logic                             sim_irq_o
);
   import sbtt_pkg::*;

   logic                  scl_s1_ff, scl_s2_ff, scl_s3_ff;
   logic                  sda_s1_ff, sda_s2_ff, sda_s3_ff;
   sbtt_state_t           state_ff, nxt_state;
   logic [3:0]            bitcnt_ff, nxt_bitcnt;
   logic [7:0]            shift_ff, nxt_shift;
   logic [7:0]            buf_ff, nxt_buf;
   logic [6:0]            own_ff, nxt_own;
   logic [7:0]            ctl1_ff, nxt_ctl1;
   sbtt_ctl2_t            ctl2_ff, nxt_ctl2;
   sbtt_toc_t             toc_ff, nxt_toc;
   logic [TO_CNT_W-1:0]   to_cnt_ff, nxt_to_cnt;
   logic                  active_ff, nxt_active;
   logic [SUB_CNT_W-1:0]  sub_cnt_ff, nxt_sub_cnt;
   logic [TICK_CNT_W-1:0] tick_cnt_ff, nxt_tick_cnt;
   logic                  sda_oe_ff, nxt_sda_oe;
   logic                  scl_oe_ff, nxt_scl_oe;
   logic                  irq_ff, nxt_irq;
   logic                  wait_ff, nxt_wait;
   logic [7:0]            rdata_ff, nxt_rdata;
   logic                  pin_lvl_ff;
   logic                  scl_rise, scl_fall, start_c, stop_c;
   logic                  bus_req, acc, wr0, rel, match_c;
   logic                  sub_tick, to_tick, to_hit;

   assign avs_readdata_o    = {24'h000000, rdata_ff};
   assign avs_waitrequest_o = wait_ff;
   assign scl_o             = pin_lvl_ff;
   assign sda_o             = pin_lvl_ff;
   assign scl_oe_o          = scl_oe_ff;
   assign sda_oe_o          = sda_oe_ff;
   assign sim_irq_o         = irq_ff;

   // Line conditions from the synchronised pins.
   assign scl_rise = scl_s2_ff && !scl_s3_ff;
   assign scl_fall = !scl_s2_ff && scl_s3_ff;
   assign start_c  = scl_s2_ff && scl_s3_ff && sda_s3_ff && !sda_s2_ff;
   assign stop_c   = scl_s2_ff && scl_s3_ff && !sda_s3_ff && sda_s2_ff;

   // Bus access is taken in the cycle in which waitrequest is low.
   assign bus_req = avs_read_i || avs_write_i;
   assign acc     = bus_req && !wait_ff;
   assign wr0     = acc && avs_write_i && avs_byteenable_i[0];
   assign rel     = (state_ff == ST_STALL) && acc && (avs_address_i == OFS_DATA) &&
                    (ctl2_ff.transmit_mode_bit ? wr0 : avs_read_i);
   assign match_c = (state_ff == ST_ADDR) && scl_fall && (bitcnt_ff == 4'd8) &&
                    (shift_ff[7:1] == own_ff) && ctl1_ff[CTL1_EN_BIT];

   // Free-running sub clock and the divide-by-32 time-out tick.
   assign sub_tick = (sub_cnt_ff == SUB_CNT_W'(SUB_DIV_P - 1));
   assign to_tick  = sub_tick && (tick_cnt_ff == TICK_CNT_W'(TO_TICK_SUB - 1));
   assign to_hit   = active_ff && toc_ff.timeout_enable_bit &&
                     (to_cnt_ff == ({1'b0, toc_ff.timeout_period_select} + 7'h01));

   always_comb
   begin
      nxt_state    = state_ff;
      nxt_bitcnt   = bitcnt_ff;
      nxt_shift    = shift_ff;
      nxt_buf      = buf_ff;
      nxt_own      = own_ff;
      nxt_ctl1     = ctl1_ff;
      nxt_ctl2     = ctl2_ff;
      nxt_toc      = toc_ff;
      nxt_to_cnt   = to_cnt_ff;
      nxt_active   = active_ff;
      nxt_sda_oe   = sda_oe_ff;
      nxt_scl_oe   = scl_oe_ff;
      nxt_irq      = 1'b0;
      nxt_wait     = !(bus_req && wait_ff);
      nxt_rdata    = rdata_ff;
      nxt_sub_cnt  = sub_tick ? '0 : sub_cnt_ff + 1'b1;
      nxt_tick_cnt = tick_cnt_ff;
      if (sub_tick)
      begin
         nxt_tick_cnt = tick_cnt_ff + 1'b1;
      end
      // Read data are prepared one cycle before waitrequest drops.
      if (bus_req && wait_ff)
      begin
         case (avs_address_i)
            OFS_DATA: nxt_rdata = buf_ff;
            OFS_OWN:  nxt_rdata = {own_ff, 1'b0};
            OFS_CTL1: nxt_rdata = ctl1_ff;
            OFS_CTL2: nxt_rdata = ctl2_ff;
            OFS_TOC:  nxt_rdata = toc_ff;
            default:  nxt_rdata = 8'h00;
         endcase
      end
      if (wr0)
      begin
         case (avs_address_i)
            OFS_DATA: nxt_buf = avs_writedata_i[7:0];
            OFS_OWN:  nxt_own = avs_writedata_i[7:1];
            OFS_CTL1: nxt_ctl1 = avs_writedata_i[7:0];
            OFS_CTL2:
            begin
               nxt_ctl2.transmit_mode_bit = avs_writedata_i[CTL2_TX_BIT];
               nxt_ctl2.sent_ack_bit      = avs_writedata_i[CTL2_ACK_BIT];
               if (!avs_writedata_i[CTL2_BD_BIT])
               begin
                  nxt_ctl2.byte_done = 1'b0;
               end
            end
            OFS_TOC:
            begin
               nxt_toc.timeout_enable_bit    = avs_writedata_i[TOC_EN_BIT];
               nxt_toc.timeout_period_select = avs_writedata_i[TO_SEL_W-1:0];
               if (!avs_writedata_i[TOC_FLAG_BIT])
               begin
                  nxt_toc.timeout_flag = 1'b0;
               end
            end
            default: nxt_buf = buf_ff;
         endcase
      end
      case (state_ff)
         ST_ADDR:
         begin
            if (scl_rise)
            begin
               nxt_shift  = {shift_ff[6:0], sda_s2_ff};
               nxt_bitcnt = bitcnt_ff + 4'd1;
            end
            if (scl_fall && (bitcnt_ff == 4'd8))
            begin
               nxt_state = ST_IDLE;
               if (match_c)
               begin
                  nxt_state                          = ST_ADDR_ACK;
                  nxt_sda_oe                         = 1'b1;
                  nxt_ctl2.address_match_flag        = 1'b1;
                  nxt_ctl2.read_write_direction_flag = shift_ff[0];
                  nxt_active                         = 1'b1;
                  nxt_to_cnt                         = '0;
                  nxt_irq                            = 1'b1;
               end
            end
         end
         ST_ADDR_ACK:
         begin
            if (scl_fall)
            begin
               nxt_sda_oe = 1'b0;
               nxt_scl_oe = 1'b1;
               nxt_state  = ST_STALL;
            end
         end
         ST_STALL:
         begin
            if (rel)
            begin
               nxt_scl_oe                  = 1'b0;
               nxt_bitcnt                  = 4'd0;
               nxt_ctl2.address_match_flag = 1'b0;
               nxt_state                   = ST_RX;
               if (ctl2_ff.transmit_mode_bit)
               begin
                  nxt_shift  = avs_writedata_i[7:0];
                  nxt_sda_oe = !avs_writedata_i[7];
                  nxt_state  = ST_TX;
               end
            end
         end
         ST_RX:
         begin
            if (scl_rise)
            begin
               nxt_shift  = {shift_ff[6:0], sda_s2_ff};
               nxt_bitcnt = bitcnt_ff + 4'd1;
            end
            if (scl_fall && (bitcnt_ff == 4'd8))
            begin
               nxt_buf    = shift_ff;
               nxt_sda_oe = !ctl2_ff.sent_ack_bit;
               nxt_state  = ST_RX_ACK;
            end
         end
         ST_RX_ACK:
         begin
            if (scl_fall)
            begin
               nxt_sda_oe         = 1'b0;
               nxt_scl_oe         = 1'b1;
               nxt_ctl2.byte_done = 1'b1;
               nxt_irq            = 1'b1;
               nxt_state          = ST_STALL;
            end
         end
         ST_TX:
         begin
            if (scl_rise)
            begin
               nxt_bitcnt = bitcnt_ff + 4'd1;
            end
            if (scl_fall)
            begin
               if (bitcnt_ff == 4'd8)
               begin
                  nxt_sda_oe = 1'b0;
                  nxt_state  = ST_TX_ACK;
               end
               else
               begin
                  nxt_shift  = {shift_ff[6:0], 1'b0};
                  nxt_sda_oe = !shift_ff[6];
               end
            end
         end
         ST_TX_ACK:
         begin
            if (scl_rise)
            begin
               nxt_ctl2.received_ack_flag = sda_s2_ff;
            end
            if (scl_fall)
            begin
               nxt_ctl2.byte_done = 1'b1;
               nxt_irq            = 1'b1;
               nxt_state          = ST_WAIT_STOP;
               if (!ctl2_ff.received_ack_flag)
               begin
                  nxt_scl_oe = 1'b1;
                  nxt_state  = ST_STALL;
               end
            end
         end
         ST_IDLE, ST_WAIT_STOP: nxt_state = state_ff;
         default: nxt_state = ST_IDLE;
      endcase
      if (start_c)
      begin
         nxt_state     = ST_ADDR;
         nxt_bitcnt    = 4'd0;
         nxt_sda_oe    = 1'b0;
         nxt_scl_oe    = 1'b0;
         nxt_ctl2.busy = 1'b1;
      end
      if (stop_c)
      begin
         nxt_state     = ST_IDLE;
         nxt_sda_oe    = 1'b0;
         nxt_scl_oe    = 1'b0;
         nxt_ctl2.busy = 1'b0;
         nxt_active    = 1'b0;
      end
      if (active_ff && toc_ff.timeout_enable_bit)
      begin
         if (scl_fall)
         begin
            nxt_to_cnt = '0;
         end
         else if (to_tick)
         begin
            nxt_to_cnt = to_cnt_ff + 1'b1;
         end
      end
      if (to_hit)
      begin
         nxt_to_cnt                 = to_cnt_ff;
         nxt_active                 = 1'b0;
         nxt_toc.timeout_enable_bit = 1'b0;
         nxt_toc.timeout_flag       = 1'b1;
         nxt_irq                    = 1'b1;
         nxt_state                  = ST_IDLE;
         nxt_bitcnt                 = 4'd0;
         nxt_shift                  = 8'h00;
         nxt_sda_oe                 = 1'b0;
         nxt_scl_oe                 = 1'b0;
         nxt_ctl2                   = CTL2_POR;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_s3_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_s3_ff <= 1'b1;
      end
      else
      begin
         scl_s1_ff <= scl_i;
         scl_s2_ff <= scl_s1_ff;
         scl_s3_ff <= scl_s2_ff;
         sda_s1_ff <= sda_i;
         sda_s2_ff <= sda_s1_ff;
         sda_s3_ff <= sda_s2_ff;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_ff    <= ST_IDLE;
         bitcnt_ff   <= 4'd0;
         shift_ff    <= 8'h00;
         buf_ff      <= 8'h00;
         own_ff      <= 7'h00;
         ctl1_ff     <= CTL1_POR;
         ctl2_ff     <= CTL2_POR;
         toc_ff      <= TOC_POR;
         to_cnt_ff   <= '0;
         active_ff   <= 1'b0;
         sub_cnt_ff  <= '0;
         tick_cnt_ff <= '0;
         sda_oe_ff   <= 1'b0;
         scl_oe_ff   <= 1'b0;
         irq_ff      <= 1'b0;
         wait_ff     <= 1'b1;
         rdata_ff    <= 8'h00;
         pin_lvl_ff  <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         bitcnt_ff   <= nxt_bitcnt;
         shift_ff    <= nxt_shift;
         buf_ff      <= nxt_buf;
         own_ff      <= nxt_own;
         ctl1_ff     <= nxt_ctl1;
         ctl2_ff     <= nxt_ctl2;
         toc_ff      <= nxt_toc;
         to_cnt_ff   <= nxt_to_cnt;
         active_ff   <= nxt_active;
         sub_cnt_ff  <= nxt_sub_cnt;
         tick_cnt_ff <= nxt_tick_cnt;
         sda_oe_ff   <= nxt_sda_oe;
         scl_oe_ff   <= nxt_scl_oe;
         irq_ff      <= nxt_irq;
         wait_ff     <= nxt_wait;
         rdata_ff    <= nxt_rdata;
         pin_lvl_ff  <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence rx_done_s;
      (state_ff == ST_RX) && scl_fall && (bitcnt_ff == 4'd8) && !to_hit;
   endsequence

   sequence tx_nack_s;
      (state_ff == ST_TX_ACK) && scl_fall && ctl2_ff.received_ack_flag && !to_hit && !stop_c;
   endsequence

   sequence tx_load_s;
      rel && ctl2_ff.transmit_mode_bit && !to_hit && !start_c && !stop_c;
   endsequence

   byte_store_a: assert property (rx_done_s |=> buf_ff == $past(shift_ff))
      else $error("received byte not stored in buffer");
   ack_ninth_a: assert property (rx_done_s ##0 !ctl2_ff.sent_ack_bit
      |=> sda_oe_o && (state_ff == ST_RX_ACK))
      else $error("acknowledge not driven on ninth clock");
   nack_release_a: assert property (tx_nack_s |=> !sda_oe_o [*2])
      else $error("data line not released after missing acknowledge");
   stall_hold_a: assert property ((state_ff == ST_STALL) |-> scl_oe_o)
      else $error("clock not held low while stalled");
   tx_msb_a: assert property (tx_load_s |=> (state_ff == ST_TX)
      && (sda_oe_o == !$past(avs_writedata_i[7])))
      else $error("first transmitted bit is not the msb");
   to_fire_a: assert property (to_hit |=> !toc_ff.timeout_enable_bit
      && toc_ff.timeout_flag && (state_ff == ST_IDLE) && (ctl2_ff == CTL2_POR) && sim_irq_o)
      else $error("time-out did not reset and flag");
   flag_hold_a: assert property (toc_ff.timeout_flag
      && !(wr0 && (avs_address_i == OFS_TOC) && !avs_writedata_i[TOC_FLAG_BIT])
      |=> toc_ff.timeout_flag)
      else $error("time-out flag cleared without software");
   to_clear_a: assert property (active_ff && toc_ff.timeout_enable_bit
      && scl_fall && !to_hit |=> to_cnt_ff == '0)
      else $error("time-out counter not cleared on clock fall");
   to_idle_a: assert property (!toc_ff.timeout_enable_bit && !match_c
      |=> $stable(to_cnt_ff) && !$rose(toc_ff.timeout_flag))
      else $error("time-out counting while disabled");
   stop_halt_a: assert property (stop_c |=> !active_ff)
      else $error("supervision still active after stop");
   match_irq_a: assert property (match_c && !to_hit && !stop_c
      |=> ctl2_ff.address_match_flag && sim_irq_o && sda_oe_o)
      else $error("address match not flagged");

endmodule // sbtt_core

/* core/sbtt_pkg.sv */
package sbtt_pkg;

   // System clock and the free-running low-speed oscillator it stands in for.
   localparam int unsigned SYS_CLK_HZ  = 50_000_000;
   localparam int unsigned SUB_CLK_HZ  = 32_000;
   localparam int unsigned SUB_DIV     = SYS_CLK_HZ / SUB_CLK_HZ;
   localparam int unsigned SUB_CNT_W   = 11;
   localparam int unsigned TO_TICK_SUB = 32;
   localparam int unsigned TICK_CNT_W  = 5;
   localparam int unsigned TO_SEL_W    = 6;
   localparam int unsigned TO_CNT_W    = 7;

   // Avalon-MM slave geometry and register byte offsets.
   localparam int unsigned AVS_AW   = 5;
   localparam int unsigned AVS_DW   = 32;
   localparam logic [4:0]  OFS_DATA = 5'h00;
   localparam logic [4:0]  OFS_OWN  = 5'h04;
   localparam logic [4:0]  OFS_CTL1 = 5'h08;
   localparam logic [4:0]  OFS_CTL2 = 5'h0c;
   localparam logic [4:0]  OFS_TOC  = 5'h10;

   // Field positions inside the writable registers.
   localparam int unsigned CTL1_EN_BIT  = 0;
   localparam int unsigned CTL2_TX_BIT  = 5;
   localparam int unsigned CTL2_ACK_BIT = 3;
   localparam int unsigned CTL2_BD_BIT  = 2;
   localparam int unsigned TOC_EN_BIT   = 7;
   localparam int unsigned TOC_FLAG_BIT = 6;

   typedef struct packed {
      logic address_match_flag;
      logic busy;
      logic transmit_mode_bit;
      logic read_write_direction_flag;
      logic sent_ack_bit;
      logic byte_done;
      logic spare;
      logic received_ack_flag;
   } sbtt_ctl2_t;

   typedef struct packed {
      logic                timeout_enable_bit;
      logic                timeout_flag;
      logic [TO_SEL_W-1:0] timeout_period_select;
   } sbtt_toc_t;

   localparam logic [7:0] CTL1_POR = 8'h00;
   localparam sbtt_ctl2_t CTL2_POR = 8'h01;
   localparam sbtt_toc_t  TOC_POR  = 8'h00;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_STALL, ST_RX,
      ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT_STOP
   } sbtt_state_t;

endpackage

/* tb/sbtt_master.sv */
`timescale 1ns/10ps
module sbtt_master
(
   input  wire logic clk_sys_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_low_o,
   output logic      sda_low_o
);
   localparam int H = 10;
   initial
   begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   task automatic hw(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // Releases the clock, honours stretching, samples data mid high phase.
   task automatic sclk(output logic s);
      hw(H);
      scl_low_o <= 1'b0;
      @(posedge clk_sys_i iff scl_i === 1'b1);
      hw(H / 2);
      s = sda_i;
      hw(H / 2);
      scl_low_o <= 1'b1;
      hw(2);
   endtask
   task automatic start();
      sda_low_o <= 1'b1;
      hw(H);
      scl_low_o <= 1'b1;
      hw(2);
   endtask
   task automatic stop();
      sda_low_o <= 1'b1;
      hw(H);
      scl_low_o <= 1'b0;
      @(posedge clk_sys_i iff scl_i === 1'b1);
      hw(H);
      sda_low_o <= 1'b0;
      hw(H);
   endtask
   // Eight bits, most significant first, then the slave's acknowledge.
   task automatic wr(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         sda_low_o <= !d[i];
         sclk(s);
      end
      sda_low_o <= 1'b0;
      sclk(ack);
   endtask
   // The master acknowledges by pulling the data line low.
   task automatic rd(input logic nack, output logic [7:0] q);
      logic s;
      for (int i = 7; i >= 0; i--)
         sclk(q[i]);
      sda_low_o <= !nack;
      sclk(s);
      sda_low_o <= 1'b0;
   endtask
endmodule // sbtt_master

/* tb/serial_slave_byte_transfer_timeout_tb.sv */
`timescale 1ns/10ps
module serial_slave_byte_transfer_timeout_tb;
   import sbtt_pkg::*;
   typedef struct packed {logic w; logic be; logic [4:0] a; logic [7:0] d;} sbtt_row_t;
   logic        clk_sys_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [4:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, q;
   logic [3:0]  avs_byteenable_i;
   logic        scl_o, scl_oe_o, sda_o, sda_oe_o, sim_irq_o, m_scl, m_sda, ack;
   wire logic   scl_w = (scl_oe_o ? scl_o : 1'b1) & !m_scl;
   wire logic   sda_w = (sda_oe_o ? sda_o : 1'b1) & !m_sda;
   logic [7:0]  b;
   int          err_total, check_count, irq_n, cyc;
   sbtt_row_t   rows [15] = '{'{0,1,5'h00,8'h00}, '{0,1,5'h04,8'h00}, '{0,1,5'h08,8'h00},
      '{0,1,5'h0c,8'h01}, '{0,1,5'h10,8'h00}, '{1,1,5'h04,8'ha4}, '{0,1,5'h04,8'ha4},
      '{1,0,5'h04,8'hff}, '{0,1,5'h04,8'ha4}, '{1,1,5'h14,8'h55}, '{0,1,5'h14,8'h00},
      '{1,1,5'h08,8'h01}, '{0,1,5'h08,8'h01}, '{1,1,5'h10,8'h01}, '{0,1,5'h10,8'h01}};
   sbtt_core #(.SUB_DIV_P(2)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sim_irq_o(sim_irq_o));
   sbtt_master m (.clk_sys_i(clk_sys_i), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
   always #10 clk_sys_i = ~clk_sys_i;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic be, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      avs_read_i       <= !w;
      avs_write_i      <= w;
      avs_address_i    <= a;
      avs_byteenable_i <= {3'h0, be};
      avs_writedata_i  <= {24'h0, d};
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_sys_i)
   begin
      irq_n += (sim_irq_o === 1'b1);
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         report_and_stop();
      end
   end
   initial
   begin
      {clk_sys_i, nrst_i, avs_read_i, avs_write_i, avs_address_i} = '0;
      {avs_writedata_i, avs_byteenable_i, err_total, check_count, irq_n, cyc} = '0;
      repeat (16) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      foreach (rows[i])
      begin
         bus(rows[i].w, rows[i].be, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("register", q, {24'h0, rows[i].d});
      end
      m.start();
      m.wr(8'ha4, ack);
      chk("address ack", ack, 1'b0);
      bus(0, 1, 5'h0c, 8'h00);
      chk("match flag", {q[7], q[4]}, 2'b10);
      chk("match irq", irq_n, 1);
      repeat (300) @(posedge clk_sys_i);
      chk("stretch held", scl_oe_o, 1'b1);
      bus(0, 1, 5'h10, 8'h00);
      chk("no timeout when off", q, 32'h01);
      bus(0, 1, 5'h00, 8'h00);
      repeat (4) @(posedge clk_sys_i);
      chk("stretch freed", scl_oe_o, 1'b0);
      m.wr(8'h6b, ack);
      chk("data ack", ack, 1'b0);
      bus(0, 1, 5'h00, 8'h00);
      chk("rx byte", q, 32'h6b);
      chk("byte irq", irq_n, 2);
      bus(1, 1, 5'h0c, 8'h08);
      m.wr(8'h4d, ack);
      chk("ack withheld", ack, 1'b1);
      bus(0, 1, 5'h00, 8'h00);
      chk("rx byte two", q, 32'h4d);
      m.stop();
      m.start();
      m.wr(8'h10, ack);
      chk("foreign address", ack, 1'b1);
      m.stop();
      bus(1, 1, 5'h10, 8'h81);
      m.start();
      m.wr(8'ha5, ack);
      chk("read address ack", ack, 1'b0);
      bus(1, 1, 5'h0c, 8'h20);
      bus(1, 1, 5'h00, 8'h1e);
      m.rd(1'b0, b);
      chk("tx byte", b, 8'h1e);
      bus(0, 1, 5'h0c, 8'h00);
      chk("ack captured", {q[0], scl_oe_o}, 2'b01);
      bus(1, 1, 5'h00, 8'h96);
      m.rd(1'b1, b);
      chk("tx byte two", b, 8'h96);
      repeat (6) @(posedge clk_sys_i);
      chk("released on nack", sda_oe_o, 1'b0);
      bus(0, 1, 5'h0c, 8'h00);
      chk("received ack", q[0], 1'b1);
      chk("tx irqs", irq_n, 6);
      m.stop();
      repeat (300) @(posedge clk_sys_i);
      bus(0, 1, 5'h10, 8'h00);
      chk("stop ends watch", q, 32'h81);
      m.start();
      m.wr(8'ha4, ack);
      bus(0, 1, 5'h10, 8'h00);
      chk("before period", q, 32'h81);
      repeat (200) @(posedge clk_sys_i);
      bus(0, 1, 5'h10, 8'h00);
      chk("timeout flag", q, 32'h41);
      chk("pins freed", {scl_oe_o, sda_oe_o}, 2'b00);
      bus(0, 1, 5'h0c, 8'h00);
      chk("ctl2 reset", q, 32'h01);
      bus(0, 1, 5'h00, 8'h00);
      chk("buffer kept", q, 32'h96);
      bus(0, 1, 5'h04, 8'h00);
      chk("own kept", q, 32'ha4);
      chk("timeout irq", irq_n, 8);
      repeat (100) @(posedge clk_sys_i);
      bus(0, 1, 5'h10, 8'h00);
      chk("flag sticky", q, 32'h41);
      bus(1, 1, 5'h10, 8'h01);
      bus(0, 1, 5'h10, 8'h00);
      chk("flag cleared", q, 32'h01);
      m.stop();
      nrst_i <= 1'b0;
      @(posedge clk_sys_i);
      chk("reset outputs", {avs_waitrequest_o, scl_oe_o, sda_oe_o, scl_o, sda_o, sim_irq_o}, 6'h20);
      nrst_i <= 1'b1;
      bus(0, 1, 5'h0c, 8'h00);
      chk("ctl2 after reset", q, 32'h01);
      bus(0, 1, 5'h10, 8'h00);
      chk("toc after reset", q, 32'h00);
      report_and_stop();
   end
endmodule // serial_slave_byte_transfer_timeout_tb
